// >>> rtl/cvs_consts.vh
// Constants of the core regulator start-up sequencer.
// Assumes a 25 MHz ref_clk and an AXI4-Lite bus with a 4-bit byte address.
`ifndef CVS_CONSTS_VH
`define CVS_CONSTS_VH

// Clock and timing
`define CVS_CLK_MHZ        25
`define CVS_START_DLY_US   100
`define CVS_START_DLY_CYC  18'h009C4
`define CVS_CLKEN_CYC      18'h0000D
`define CVS_POWER_GOOD_OUT_DLY_MS   7
`define CVS_POWER_GOOD_OUT_DLY_CYC  18'h2AB98
`define CVS_TMR_W          18

// Setpoints in units of 0.1 mV
`define CVS_BOOT_TARGET    16'h2EE0
`define CVS_VID_TOP        16'h3A98
`define CVS_VID_STEP       16'h007D
`define CVS_VID_FLOOR      7'h78
`define CVS_ZERO_TARGET    16'h0000

// Register map (byte addresses)
`define CVS_AW             4
`define CVS_REG_STATUS     4'h0
`define CVS_REG_MASK       4'h4
`define CVS_REG_CTRL       4'h8
`define CVS_REG_STATE      4'hC

// Register fields and reset values
`define CVS_EV_W           4
`define CVS_EV_START       0
`define CVS_EV_CLKEN       1
`define CVS_EV_POWER_GOOD_OUT       2
`define CVS_EV_DROP        3
`define CVS_CTRL_PERMIT    0
`define CVS_MASK_RST       4'h0
`define CVS_CTRL_RST       1'h1

// Bus responses
`define CVS_RESP_OKAY      2'h0
`define CVS_RESP_SLVERR    2'h2

`endif

// >>> rtl/cvs_vdec.v
// Voltage-code decoder: 7-bit code to target in 0.1 mV units.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
`include "cvs_consts.vh"

module cvs_vdec (
  input  wire [6:0]  code,
  output reg  [15:0] target
);

  wire [15:0] drop;

  assign drop = {9'h000, code} * `CVS_VID_STEP;

  always @* begin
    if (code >= `CVS_VID_FLOOR) begin
      target = `CVS_ZERO_TARGET;
    end else begin
      target = `CVS_VID_TOP - drop;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/cvs_timer.v
// One-shot cycle timer used by the sequencer for the start delay, the clock-enable count and the power-good delay.
// A start pulse loads the count N; done pulses one cycle early so the user moves on the Nth edge.
// Loads below two wrap past zero and finish only when the count comes round to two.
`timescale 1ns/1ns
`default_nettype none
`include "cvs_consts.vh"

module cvs_timer (
  input  wire                  ref_clk,
  input  wire                  rstn,
  input  wire                  start,
  input  wire                  abort,
  input  wire [`CVS_TMR_W-1:0] load,
  output reg                   done_q
);

  reg [`CVS_TMR_W-1:0] cnt_q;
  reg                  run_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= {`CVS_TMR_W{1'b0}};
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (abort) begin
        run_q <= 1'b0;
      end else if (start) begin
        cnt_q <= load;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {{(`CVS_TMR_W-2){1'b0}}, 2'b10}) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end
        cnt_q <= cnt_q - {{(`CVS_TMR_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/cvs_top.v
// Start-up sequencer and voltage-code decoder of a core regulator, with an AXI4-Lite register slave.
// Assumes all inputs synchronous to ref_clk; the in-band flag comes from an analog comparator.
//
// Notes on behaviour
// - Start only with supply good and enable high
// - After 100 us delay, ramp to 1.2 V
// - Force continuous conduction, ignore sleep inputs (code does so until power good; in ST_DONE sleep_in and diode_emul_in set the mode)
// - Low slew current during boot ramp
// - Within 20 mV, count 13, assert clock enable
// - Clock enable switches to fast slew, code target
// - Power good rises 7 ms after clock enable
// - Power good only pulls low, external pull-up
// - After start-up, regulate to decoded code target
// - Code zero is 1.5 V, 12.5 mV steps
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cvs_consts.vh"

module cvs_top #(
  parameter [`CVS_TMR_W-1:0] POWER_GOOD_OUT_DELAY_CYC = `CVS_POWER_GOOD_OUT_DLY_CYC
) (
  input  wire              ref_clk,
  input  wire              rstn,
  input  wire              control_supply_ok,
  input  wire              regulator_enable_in,
  input  wire              sleep_in,
  input  wire              diode_emul_in,
  input  wire [6:0]        voltage_code_in,
  input  wire              output_level_in_band,
  output reg               clk_enable_n_q,
  output reg               power_good_out_o_q,
  output reg               power_good_out_oe_q,
  output reg               continuous_conduction_q,
  output reg               diode_emulation_q,
  output reg               soft_start_run_q,
  output reg               fast_slew_q,
  output reg  [15:0]       target_q,
  output reg               irq_q,
  input  wire [`CVS_AW-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [`CVS_AW-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_DELAY = 6'h02;
  localparam [5:0] ST_RAMP  = 6'h04;
  localparam [5:0] ST_COUNT = 6'h08;
  localparam [5:0] ST_SLEW  = 6'h10;
  localparam [5:0] ST_DONE  = 6'h20;

  localparam [2:0] SEL_STATUS = 3'h4;
  localparam [2:0] SEL_MASK   = 3'h5;
  localparam [2:0] SEL_CTRL   = 3'h6;
  localparam [2:0] SEL_STATE  = 3'h7;
  localparam [2:0] SEL_NONE   = 3'h0;

  localparam [`CVS_TMR_W-1:0] START_CYC = `CVS_START_DLY_CYC;
  localparam [`CVS_TMR_W-1:0] CLKEN_CYC = `CVS_CLKEN_CYC;

  // Register decode; bit 2 marks a mapped address
  function [2:0] reg_sel;
    input [`CVS_AW-1:0] addr;
    begin
      case (addr)
        `CVS_REG_STATUS: reg_sel = SEL_STATUS;
        `CVS_REG_MASK:   reg_sel = SEL_MASK;
        `CVS_REG_CTRL:   reg_sel = SEL_CTRL;
        `CVS_REG_STATE:  reg_sel = SEL_STATE;
        default:         reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  reg  [5:0]            state_q;
  reg  [5:0]            state_d;
  reg                   tmr_start;
  reg  [`CVS_TMR_W-1:0] tmr_load;
  wire                  tmr_done;
  wire [15:0]           code_target;
  reg  [`CVS_EV_W-1:0]  ev;

  reg  [`CVS_EV_W-1:0]  status_q;
  reg  [`CVS_EV_W-1:0]  status_d;
  reg  [`CVS_EV_W-1:0]  mask_q;
  reg  [`CVS_EV_W-1:0]  mask_d;
  reg                   permit_q;
  reg  [`CVS_AW-1:0]    awaddr_q;
  reg                   aw_full_q;
  reg  [31:0]           wdata_q;
  reg  [3:0]            wstrb_q;
  reg                   w_full_q;
  wire                  wr_go;
  wire [2:0]            wr_sel;
  wire [2:0]            rd_sel;
  reg  [31:0]           rd_word;
  reg  [`CVS_EV_W-1:0]  w1c;

  cvs_vdec u_vdec (
    .code   (voltage_code_in),
    .target (code_target)
  );

  cvs_timer u_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (tmr_start),
    .abort   (~regulator_enable_in),
    .load    (tmr_load),
    .done_q  (tmr_done)
  );

  // Sequencer next state and timer loads
  always @* begin
    state_d   = state_q;
    tmr_start = 1'b0;
    tmr_load  = START_CYC;
    ev        = {`CVS_EV_W{1'b0}};
    if (!regulator_enable_in) begin
      state_d = ST_IDLE;
      ev[`CVS_EV_DROP] = (state_q != ST_IDLE);
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (control_supply_ok && permit_q) begin
            state_d   = ST_DELAY;
            tmr_start = 1'b1;
            tmr_load  = START_CYC;
            ev[`CVS_EV_START] = 1'b1;
          end
        end
        ST_DELAY: begin
          if (tmr_done) begin
            state_d = ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (output_level_in_band) begin
            state_d   = ST_COUNT;
            tmr_start = 1'b1;
            tmr_load  = CLKEN_CYC;
          end
        end
        ST_COUNT: begin
          if (tmr_done) begin
            state_d   = ST_SLEW;
            tmr_start = 1'b1;
            tmr_load  = POWER_GOOD_OUT_DELAY_CYC;
            ev[`CVS_EV_CLKEN] = 1'b1;
          end
        end
        ST_SLEW: begin
          if (tmr_done) begin
            state_d = ST_DONE;
            ev[`CVS_EV_POWER_GOOD_OUT] = 1'b1;
          end
        end
        ST_DONE: begin
          state_d = ST_DONE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer outputs, all registered from the next state
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q                 <= ST_IDLE;
      clk_enable_n_q          <= 1'b1;
      power_good_out_o_q      <= 1'b0;
      power_good_out_oe_q     <= 1'b1;
      continuous_conduction_q <= 1'b1;
      diode_emulation_q       <= 1'b0;
      soft_start_run_q        <= 1'b0;
      fast_slew_q             <= 1'b0;
      target_q                <= `CVS_ZERO_TARGET;
    end else begin
      state_q             <= state_d;
      power_good_out_o_q  <= 1'b0;
      clk_enable_n_q      <= ~((state_d == ST_SLEW) || (state_d == ST_DONE));
      power_good_out_oe_q <= (state_d != ST_DONE);
      fast_slew_q         <= (state_d == ST_SLEW) || (state_d == ST_DONE);
      soft_start_run_q    <= (state_d != ST_IDLE) && (state_d != ST_DELAY);
      if (state_d == ST_DONE) begin
        continuous_conduction_q <= ~sleep_in;
        diode_emulation_q       <= sleep_in | diode_emul_in;
      end else begin
        continuous_conduction_q <= 1'b1;
        diode_emulation_q       <= 1'b0;
      end
      case (state_d)
        ST_RAMP:  target_q <= `CVS_BOOT_TARGET;
        ST_COUNT: target_q <= `CVS_BOOT_TARGET;
        ST_SLEW:  target_q <= code_target;
        ST_DONE:  target_q <= code_target;
        default:  target_q <= `CVS_ZERO_TARGET;
      endcase
    end
  end

  // Write channel: address and data taken in either order
  assign wr_go  = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_sel = reg_sel(awaddr_q);
  assign rd_sel = reg_sel(s_axi_araddr);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CVS_RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= {`CVS_AW{1'b0}};
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_full_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_full_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q     <= 1'b0;
        w_full_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_sel[2] ? `CVS_RESP_OKAY : `CVS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register file: sticky status, mask, control; set wins over clear
  always @* begin
    w1c    = {`CVS_EV_W{1'b0}};
    mask_d = mask_q;
    if (wr_go && wstrb_q[0]) begin
      if (wr_sel == SEL_STATUS) begin
        w1c = wdata_q[`CVS_EV_W-1:0];
      end
      if (wr_sel == SEL_MASK) begin
        mask_d = wdata_q[`CVS_EV_W-1:0];
      end
    end
    status_d = (status_q & ~w1c) | ev;
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= {`CVS_EV_W{1'b0}};
      mask_q   <= `CVS_MASK_RST;
      permit_q <= `CVS_CTRL_RST;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= |(status_d & mask_d);
      if (wr_go && wstrb_q[0]) begin
        if (wr_sel == SEL_CTRL) begin
          permit_q <= wdata_q[`CVS_CTRL_PERMIT];
        end
      end
    end
  end

  // Read channel
  always @* begin
    case (rd_sel)
      SEL_STATUS: rd_word = {{(32-`CVS_EV_W){1'b0}}, status_q};
      SEL_MASK:   rd_word = {{(32-`CVS_EV_W){1'b0}}, mask_q};
      SEL_CTRL:   rd_word = {31'h00000000, permit_q};
      SEL_STATE:  rd_word = {target_q, 6'h00, clk_enable_n_q, ~power_good_out_oe_q, 2'h0, state_q};
      default:    rd_word = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CVS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_sel[2] ? `CVS_RESP_OKAY : `CVS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/cvs_monitor.sv
// Checker for cvs_top start-up sequencing and code tracking.
// Assumes one ref_clk domain with rstn active low.
`timescale 1ns/1ns
`default_nettype none
module cvs_monitor #(
  parameter int POWER_GOOD_OUT_DELAY_CYC = 20
) (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        control_supply_ok,
  input wire logic        regulator_enable_in,
  input wire logic [6:0]  voltage_code_in,
  input wire logic        output_level_in_band,
  input wire logic        clk_enable_n_q,
  input wire logic        power_good_out_o_q,
  input wire logic        power_good_out_oe_q,
  input wire logic        continuous_conduction_q,
  input wire logic        diode_emulation_q,
  input wire logic        soft_start_run_q,
  input wire logic        fast_slew_q,
  input wire logic [15:0] target_q
);
  localparam int PGM1 = POWER_GOOD_OUT_DELAY_CYC - 1;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  function automatic logic [15:0] dec(input logic [6:0] c);
    return (c >= 7'h78) ? 16'h0000 : 16'h3A98 - 16'h007D * c;
  endfunction
  a_drop_idle: assert property (!regulator_enable_in |=> clk_enable_n_q && power_good_out_oe_q && target_q == 16'h0000)
    else $error("enable drop did not return outputs to idle");
  a_start_gate: assert property ($rose(soft_start_run_q) |-> control_supply_ok && regulator_enable_in)
    else $error("ramp began without supply and enable");
  a_boot_ramp: assert property ($rose(soft_start_run_q) |-> target_q == 16'h2EE0 && !fast_slew_q && clk_enable_n_q)
    else $error("ramp start without boot target and low slew");
  a_cont_forced: assert property (power_good_out_oe_q && $past(power_good_out_oe_q) |-> continuous_conduction_q && !diode_emulation_q)
    else $error("conduction mode not forced during start-up");
  a_clken_count: assert property ($rose(output_level_in_band) && soft_start_run_q && clk_enable_n_q |-> ##13 clk_enable_n_q ##1 !clk_enable_n_q)
    else $error("clock enable not asserted after 13 cycles");
  a_fast_code: assert property ($fell(clk_enable_n_q) |-> fast_slew_q && target_q == dec($past(voltage_code_in)))
    else $error("clock enable without fast slew and code target");
  a_power_good_out_delay: assert property ($fell(clk_enable_n_q) |-> ##PGM1 power_good_out_oe_q ##1 !power_good_out_oe_q)
    else $error("power good release at wrong cycle");
  a_od_low: assert property (!power_good_out_o_q)
    else $error("power good drives a high level");
  a_code_track: assert property (!clk_enable_n_q && !$past(clk_enable_n_q) |-> target_q == dec($past(voltage_code_in)))
    else $error("target does not follow the code");
  c_ramp: cover property ($rose(soft_start_run_q));
  c_clken: cover property ($fell(clk_enable_n_q));
  c_power_good_out: cover property ($fell(power_good_out_oe_q));
  c_drop: cover property ($fell(regulator_enable_in));
endmodule
bind cvs_top cvs_monitor #(.POWER_GOOD_OUT_DELAY_CYC(POWER_GOOD_OUT_DELAY_CYC)) u_mon (.ref_clk, .rstn, .control_supply_ok,
  .regulator_enable_in, .voltage_code_in, .output_level_in_band, .clk_enable_n_q, .power_good_out_o_q,
  .power_good_out_oe_q, .continuous_conduction_q, .diode_emulation_q, .soft_start_run_q, .fast_slew_q, .target_q);
`default_nettype wire

// >>> testbench/cvs_cpu_model.sv
// Processor side: presents the code, reports the output reaching the boot band, pulls power good up.
// Assumes the ramp takes ramp_cyc cycles once the soft-start runs.
`timescale 1ns/1ns
`default_nettype none
module cvs_cpu_model (
  input  wire logic       ref_clk,
  input  wire logic       soft_start_run_q,
  input  wire logic       power_good_out_o_q,
  input  wire logic       power_good_out_oe_q,
  input  wire logic [6:0] code_req,
  input  wire logic [7:0] ramp_cyc,
  output var  logic [6:0] voltage_code_in,
  output var  logic       output_level_in_band,
  output wire logic       power_good_wire
);
  logic [7:0] cnt_q;
  // Pull-up gives the high level while released
  assign power_good_wire = power_good_out_oe_q ? power_good_out_o_q : 1'b1;
  initial begin
    cnt_q = 8'h00;
    output_level_in_band = 1'b0;
    voltage_code_in = 7'h00;
  end
  always @(posedge ref_clk) begin
    voltage_code_in <= code_req;
    if (!soft_start_run_q) begin
      cnt_q <= 8'h00;
      output_level_in_band <= 1'b0;
    end else if (cnt_q < ramp_cyc) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      output_level_in_band <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Bench for cvs_top: start-up order and timing, code decode, status and interrupt.
// Assumes the processor model drives the code and band inputs.
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int PGD = 20;
  localparam int START_CYC = 100 * 25;
  logic ref_clk, rstn, control_supply_ok, regulator_enable_in, sleep_in, diode_emul_in, output_level_in_band;
  logic clk_enable_n_q, power_good_out_o_q, power_good_out_oe_q, continuous_conduction_q, diode_emulation_q;
  logic soft_start_run_q, fast_slew_q, irq_q, power_good_wire;
  logic [6:0] voltage_code_in, code_req;
  logic [7:0] ramp_cyc;
  logic [15:0] target_q;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_errors, comparisons, i, n;
  typedef struct { logic [6:0] c; logic [15:0] t; } cvs_row_t;
  cvs_row_t rows [8] = '{'{7'h00, 16'h3A98}, '{7'h01, 16'h3A1B}, '{7'h40, 16'h1B58}, '{7'h29, 16'h2693},
                         '{7'h18, 16'h2EE0}, '{7'h77, 16'h007D}, '{7'h78, 16'h0000}, '{7'h7F, 16'h0000}};
  cvs_top #(.POWER_GOOD_OUT_DELAY_CYC(18'(PGD))) dut (.*);
  cvs_cpu_model u_cpu (.*);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", 2'h0, s_axi_bresp);
        s_axi_bready <= 1'b0;
        t = 99;
      end
    end
    if (t < 99) chk("write done", 1, 0);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int t;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk("rdata", d, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
        s_axi_rready <= 1'b0;
        t = 99;
      end
    end
    if (t < 99) chk("read done", 1, 0);
  endtask
  task automatic complete_run;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial begin
    {rstn, control_supply_ok, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {regulator_enable_in, sleep_in, diode_emul_in} = 3'h7;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    code_req = 7'h18;
    ramp_cyc = 8'h1E;
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chk("clk_en_n reset", 1, clk_enable_n_q);
    chk("power_good_out reset", 0, power_good_wire);
    axr(4'h4, 32'h0, 2'h0);
    axr(4'h8, 32'h1, 2'h0);
    axr(4'h2, 32'h0, 2'h2);
    axw(4'h4, 32'hF);
    repeat (100) @(posedge ref_clk);
    chk("ramp refused", 0, soft_start_run_q);
    chk("irq refused", 0, irq_q);
    $display("test reset and refusal done");
    control_supply_ok <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!soft_start_run_q && n < 5000);
    chk("start delay", START_CYC + 2, n);
    chk("boot target", 16'h2EE0, target_q);
    chk("slow slew", 0, fast_slew_q);
    chk("forced mode", 2'b10, {continuous_conduction_q, diode_emulation_q});
    chk("irq start", 1, irq_q);
    n = 0;
    while (clk_enable_n_q && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    chk("clk_en_n", 0, clk_enable_n_q);
    chk("fast slew", 1, fast_slew_q);
    chk("forced mode", 2'b10, {continuous_conduction_q, diode_emulation_q});
    n = 0;
    while (!power_good_wire && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    chk("power_good_out delay", PGD, n);
    axr(4'h0, 32'h7, 2'h0);
    axw(4'h0, 32'h7);
    axr(4'h0, 32'h0, 2'h0);
    chk("irq cleared", 0, irq_q);
    repeat (3) @(posedge ref_clk);
    chk("sleep mode", 2'b01, {continuous_conduction_q, diode_emulation_q});
    $display("test start-up done");
    for (i = 0; i < 8; i++) begin
      code_req <= rows[i].c;
      repeat (4) @(posedge ref_clk);
      chk("target", rows[i].t, target_q);
    end
    $display("test decode done");
    regulator_enable_in <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("drop clk_en_n", 1, clk_enable_n_q);
    chk("drop power_good_out", 0, power_good_wire);
    chk("drop target", 16'h0, target_q);
    chk("irq drop", 1, irq_q);
    axr(4'h0, 32'h8, 2'h0);
    axw(4'h4, 32'h0);
    chk("irq masked", 0, irq_q);
    axw(4'h4, 32'hF);
    chk("irq unmasked", 1, irq_q);
    axw(4'h0, 32'hF);
    chk("irq clear", 0, irq_q);
    $display("test drop and interrupt done");
    complete_run();
  end
endmodule
`default_nettype wire
